// *** inc/dcc_pkg.sv ***
// constants shared by the dma channel configuration block
package dcc_pkg;

    // ==================================================================
    // register offsets
    localparam logic [11:0] CFG_OFS     = 12'h100;
    localparam logic [11:0] STAT_OFS    = 12'h104;
    localparam logic [11:0] CNT_OFS     = 12'h110;
    localparam logic [11:0] CNT_RLD_OFS = 12'h11C;

    // ==================================================================
    // configuration layout and reset
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;
    localparam logic [31:0] CFG_WMASK = 32'hDF77_FFFF;
    localparam int CTZIEN_BIT  = 31;
    localparam int CHDIEN_BIT  = 30;
    localparam int BRST_LSB    = 24;
    localparam int DSTINC_BIT  = 22;
    localparam int DSTWD_LSB   = 20;
    localparam int SRCINC_BIT  = 18;
    localparam int SRCWD_LSB   = 16;
    localparam int PSSEL_LSB   = 14;
    localparam int TOSEL_LSB   = 11;
    localparam int REQWAIT_BIT = 10;
    localparam int REQSEL_LSB  = 4;
    localparam int PRI_LSB     = 2;
    localparam int RLDEN_BIT   = 1;
    localparam int CHEN_BIT    = 0;

    // ==================================================================
    // status, count and reload layout
    localparam int ST_ACTIVE_BIT   = 0;
    localparam int ST_IPEND_BIT    = 1;
    localparam int ST_CTZ_BIT      = 2;
    localparam int ST_RLD_BIT      = 3;
    localparam int ST_TO_BIT       = 6;
    localparam int CNT_RLD_EN_BIT  = 31;
    localparam logic [23:0] CNT_RESET = 24'h00_0000;

    // ==================================================================
    // encodings
    localparam logic [1:0] WD_BYTE     = 2'h0;
    localparam logic [1:0] WD_HALF     = 2'h1;
    localparam logic [1:0] WD_WORD     = 2'h2;
    localparam logic [5:0] REQ_MEM2MEM = 6'h00;
    localparam logic [5:0] REQ_TX_BASE = 6'h20;
    localparam logic [1:0] PSSEL_OFF   = 2'h0;
    localparam logic [1:0] PSSEL_256   = 2'h1;
    localparam logic [1:0] PSSEL_64K   = 2'h2;
    localparam logic [1:0] PSSEL_16M   = 2'h3;
    localparam int PSC_SHIFT_256 = 8;
    localparam int PSC_SHIFT_64K = 16;
    localparam int PSC_SHIFT_16M = 24;
    localparam logic [3:0] TO_EXP_BASE = 4'h2;

endpackage : dcc_pkg

// *** hdl/dcc_fifo.sv ***
// channel byte fifo with registered full and empty flags
`timescale 1ns/10ps
module dcc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    // clock and reset
    input  wire logic                       sys_clk_i,
    input  wire logic                       rst_b_i,
    // fill side
    input  wire logic                       in_valid_i,
    input  wire logic [WIDTH-1:0]           in_data_i,
    output logic                            in_ready_o,
    // drain side
    output logic                            out_valid_o,
    output logic [WIDTH-1:0]                out_data_o,
    input  wire logic                       out_ready_i,
    // fill level
    output logic [$clog2(DEPTH+1)-1:0]      level_o
);

    localparam int AW = $clog2(DEPTH);
    localparam int LW = $clog2(DEPTH+1);

    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
    begin : g_bad_param
        $error("dcc_fifo: depth must be a power of two of at least 2");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wptr;
        logic [AW-1:0]               rptr;
        logic [LW-1:0]               level;
        logic                        full;
        logic                        empty;
    } dcc_fifo_state_t;

    dcc_fifo_state_t s_reg;
    dcc_fifo_state_t s_next;
    logic            push;
    logic            pop;

    assign push        = in_valid_i & ~s_reg.full;
    assign pop         = out_ready_i & ~s_reg.empty;
    assign in_ready_o  = ~s_reg.full;
    assign out_valid_o = ~s_reg.empty;
    assign out_data_o  = s_reg.mem[s_reg.rptr];
    assign level_o     = s_reg.level;

    always_comb
    begin
        s_next = s_reg;
        if (push)
        begin
            s_next.mem[s_reg.wptr] = in_data_i;
            s_next.wptr            = s_reg.wptr + AW'(1);
        end
        if (pop)
        begin
            s_next.rptr = s_reg.rptr + AW'(1);
        end
        if (push && !pop)
        begin
            s_next.level = s_reg.level + LW'(1);
        end
        else if (pop && !push)
        begin
            s_next.level = s_reg.level - LW'(1);
        end
        s_next.full  = (s_next.level == LW'(DEPTH));
        s_next.empty = (s_next.level == '0);
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            s_reg       <= '0;
            s_reg.empty <= 1'b1;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

endmodule : dcc_fifo

// *** hdl/dcc_channel_config.sv ***
// dma channel configuration, status, count and timeout with byte fifo
`timescale 1ns/10ps
module dcc_channel_config #(
    parameter int DATA_W     = 8,
    parameter int FIFO_DEPTH = 32,
    parameter int NUM_REQ    = 64
) (
    // clock and reset
    input  wire logic                sys_clk_i,
    input  wire logic                rst_b_i,
    // register port
    input  wire logic [11:0]         reg_addr_i,
    input  wire logic                reg_wr_i,
    input  wire logic                reg_rd_i,
    input  wire logic [31:0]         reg_wdata_i,
    output logic      [31:0]         reg_rdata_o,
    output logic                     reg_ack_o,
    // global interrupt
    input  wire logic                glb_int_en_i,
    output logic                     ipend_o,
    // requests and bus control
    input  wire logic [NUM_REQ-1:0]  periph_req_i,
    output logic                     dma_req_o,
    output logic [1:0]               pri_o,
    output logic [4:0]               burst_o,
    output logic                     src_inc_o,
    output logic                     dst_inc_o,
    output logic [2:0]               src_bytes_o,
    output logic [2:0]               dst_bytes_o,
    output logic                     active_o,
    output logic                     reload_o,
    output logic                     timeout_o,
    // fill side of the channel fifo
    input  wire logic                rd_valid_i,
    input  wire logic [DATA_W-1:0]   rd_data_i,
    output logic                     rd_ready_o,
    // drain side of the channel fifo
    output logic                     wr_valid_o,
    output logic [DATA_W-1:0]        wr_data_o,
    input  wire logic                wr_ready_i
);

    localparam int LW = $clog2(FIFO_DEPTH+1);

    if (NUM_REQ < 2 || NUM_REQ > 64 || FIFO_DEPTH < 32)
    begin : g_bad_param
        $error("dcc_channel_config: NUM_REQ 2..64 and FIFO_DEPTH of 32 or more");
    end

    // ==================================================================
    // state
    typedef struct packed {
        logic [31:0] cfg;
        logic        active;
        logic        ctz_st;
        logic        rld_st;
        logic        to_st;
        logic        ipend;
        logic        hold;
        logic        done;
        logic [23:0] cnt;
        logic [23:0] rld_cnt;
        logic [23:0] psc;
        logic [9:0]  tmr;
        logic [31:0] rdata;
        logic        ack;
        logic        reload;
        logic        req;
        logic [2:0]  src_bytes;
        logic [2:0]  dst_bytes;
    } dcc_state_t;

    dcc_state_t        s_reg;
    dcc_state_t        s_next;
    logic              fifo_in_valid;
    logic              fifo_in_ready;
    logic              fifo_out_valid;
    logic [LW-1:0]     fifo_level;
    logic              push;
    logic              pop;
    logic              wr_cfg;
    logic              wr_stat;
    logic              wr_cnt;
    logic              wr_rld;
    logic [5:0]        reqsel;
    logic              is_tx;
    logic              is_rx;
    logic              eff_req;

    function automatic logic [2:0] wd_bytes(input logic [1:0] wd);
        logic [2:0] b;
        b = 3'h1;
        if (wd == dcc_pkg::WD_HALF)
        begin
            b = 3'h2;
        end
        else if (wd == dcc_pkg::WD_WORD)
        begin
            b = 3'h4;
        end
        return b;
    endfunction : wd_bytes

    // ==================================================================
    // decode
    assign wr_cfg  = reg_wr_i && (reg_addr_i == dcc_pkg::CFG_OFS);
    assign wr_stat = reg_wr_i && (reg_addr_i == dcc_pkg::STAT_OFS);
    assign wr_cnt  = reg_wr_i && (reg_addr_i == dcc_pkg::CNT_OFS);
    assign wr_rld  = reg_wr_i && (reg_addr_i == dcc_pkg::CNT_RLD_OFS);
    assign reqsel  = s_reg.cfg[dcc_pkg::REQSEL_LSB +: 6];
    assign eff_req = (reqsel == dcc_pkg::REQ_MEM2MEM) ||
                     ((32'(reqsel) < NUM_REQ) && periph_req_i[reqsel]);

    // bytes accepted only while running, so stray source beats never count
    assign fifo_in_valid = rd_valid_i & s_reg.active;
    assign push          = fifo_in_valid & fifo_in_ready;
    assign pop           = fifo_out_valid & wr_ready_i;

    // ==================================================================
    // next state
    always_comb
    begin
        logic [31:0] wcfg;
        logic        tick;
        logic [9:0]  to_limit;
        logic        timeout;
        logic [5:0]  wsel;
        logic [2:0]  sb;
        logic [2:0]  db;
        wcfg     = '0;
        tick     = 1'b0;
        timeout  = 1'b0;
        sb       = wd_bytes(s_reg.cfg[dcc_pkg::SRCWD_LSB +: 2]);
        db       = wd_bytes(s_reg.cfg[dcc_pkg::DSTWD_LSB +: 2]);
        wsel     = reg_wdata_i[dcc_pkg::REQSEL_LSB +: 6];
        is_tx    = (wsel >= dcc_pkg::REQ_TX_BASE);
        is_rx    = (wsel != dcc_pkg::REQ_MEM2MEM) && !is_tx;
        to_limit = 10'(11'h001 << ({1'b0, s_reg.cfg[dcc_pkg::TOSEL_LSB +: 3]}
                                   + dcc_pkg::TO_EXP_BASE));
        s_next        = s_reg;
        s_next.ack    = reg_wr_i | reg_rd_i;
        s_next.reload = 1'b0;
        s_next.psc    = s_reg.psc + 24'h00_0001;

        // software clears go first so that a same-cycle event wins
        if (wr_stat)
        begin
            if (reg_wdata_i[dcc_pkg::ST_CTZ_BIT] || reg_wdata_i[dcc_pkg::ST_RLD_BIT] ||
                reg_wdata_i[dcc_pkg::ST_TO_BIT])
            begin
                s_next.ipend = 1'b0;
            end
            if (reg_wdata_i[dcc_pkg::ST_CTZ_BIT])
            begin
                s_next.ctz_st = 1'b0;
            end
            if (reg_wdata_i[dcc_pkg::ST_RLD_BIT])
            begin
                s_next.rld_st = 1'b0;
            end
            if (reg_wdata_i[dcc_pkg::ST_TO_BIT])
            begin
                s_next.to_st = 1'b0;
            end
        end

        wcfg = reg_wdata_i & dcc_pkg::CFG_WMASK;
        // no destination stepping toward a peripheral
        if (is_tx)
        begin
            wcfg[dcc_pkg::DSTINC_BIT] = 1'b0;
        end
        // no source stepping from a peripheral
        if (is_rx)
        begin
            wcfg[dcc_pkg::SRCINC_BIT] = 1'b0;
        end
        if (wr_cfg)
        begin
            s_next.cfg = wcfg;
            // enable write starts or stops the channel
            if (wcfg[dcc_pkg::CHEN_BIT] && !s_reg.active)
            begin
                s_next.active = 1'b1;
                s_next.done   = 1'b0;
                s_next.tmr    = '0;
                // hold the timer until the first transaction
                s_next.hold   = wcfg[dcc_pkg::REQWAIT_BIT];
            end
            else if (!wcfg[dcc_pkg::CHEN_BIT])
            begin
                s_next.active = 1'b0;
            end
        end
        if (wr_rld)
        begin
            s_next.rld_cnt = reg_wdata_i[23:0];
            s_next.cfg[dcc_pkg::RLDEN_BIT] = reg_wdata_i[dcc_pkg::CNT_RLD_EN_BIT];
        end
        if (wr_cnt)
        begin
            s_next.cnt = reg_wdata_i[23:0];
        end
        else if (push && (s_reg.cnt != dcc_pkg::CNT_RESET))
        begin
            s_next.cnt = s_reg.cnt - 24'h00_0001;
            if (s_reg.cnt == 24'h00_0001)
            begin
                s_next.ctz_st = 1'b1;
                if (s_reg.cfg[dcc_pkg::CTZIEN_BIT] && glb_int_en_i)
                begin
                    s_next.ipend = 1'b1;
                end
                // reload count, address logic follows reload_o
                if (s_reg.cfg[dcc_pkg::RLDEN_BIT])
                begin
                    s_next.cnt    = s_reg.rld_cnt;
                    s_next.reload = 1'b1;
                    s_next.rld_st = 1'b1;
                end
                else
                begin
                    s_next.done = 1'b1;
                end
            end
        end

        // prescaled tick from the free running divider
        case (s_reg.cfg[dcc_pkg::PSSEL_LSB +: 2])
            dcc_pkg::PSSEL_256: tick = &s_reg.psc[dcc_pkg::PSC_SHIFT_256-1:0];
            dcc_pkg::PSSEL_64K: tick = &s_reg.psc[dcc_pkg::PSC_SHIFT_64K-1:0];
            dcc_pkg::PSSEL_16M: tick = &s_reg.psc[dcc_pkg::PSC_SHIFT_16M-1:0];
            default:            tick = 1'b0;
        endcase
        if (push || pop)
        begin
            s_next.hold = 1'b0;
        end
        if (!s_reg.active || s_reg.hold || push || pop)
        begin
            s_next.tmr = (wr_cfg && !s_reg.active) ? s_next.tmr : '0;
        end
        else if (tick)
        begin
            if (s_reg.tmr == to_limit - 10'h001)
            begin
                timeout      = 1'b1;
                s_next.tmr   = '0;
                s_next.to_st = 1'b1;
            end
            else
            begin
                s_next.tmr = s_reg.tmr + 10'h001;
            end
        end

        // channel stops on timeout or once drained after count-to-zero
        if (s_reg.active && (timeout || (s_reg.done && !fifo_out_valid && !push)))
        begin
            s_next.active = 1'b0;
        end
        // enable clears itself when the channel stops
        if (s_reg.active && !s_next.active)
        begin
            s_next.cfg[dcc_pkg::CHEN_BIT] = 1'b0;
            if (s_reg.cfg[dcc_pkg::CHDIEN_BIT] && glb_int_en_i)
            begin
                s_next.ipend = 1'b1;
            end
        end

        // request a burst only when it fits the fifo
        s_next.req = s_reg.active && !s_reg.done && (s_reg.cnt != dcc_pkg::CNT_RESET) &&
                     eff_req &&
                     ((LW'(FIFO_DEPTH) - fifo_level) >
                      LW'(s_reg.cfg[dcc_pkg::BRST_LSB +: 5]));

        // read width capped by remaining count
        s_next.src_bytes = (s_reg.cnt < 24'(sb)) ? s_reg.cnt[2:0] : sb;
        // write width capped by fifo fill
        s_next.dst_bytes = (fifo_level < LW'(db)) ? fifo_level[2:0] : db;

        // status shows active; reserved bits read zero
        if (reg_rd_i && (reg_addr_i == dcc_pkg::CFG_OFS))
        begin
            s_next.rdata = s_reg.cfg & dcc_pkg::CFG_WMASK;
        end
        else if (reg_rd_i && (reg_addr_i == dcc_pkg::STAT_OFS))
        begin
            s_next.rdata = '0;
            s_next.rdata[dcc_pkg::ST_ACTIVE_BIT] = s_reg.active;
            s_next.rdata[dcc_pkg::ST_IPEND_BIT]  = s_reg.ipend;
            s_next.rdata[dcc_pkg::ST_CTZ_BIT]    = s_reg.ctz_st;
            s_next.rdata[dcc_pkg::ST_RLD_BIT]    = s_reg.rld_st;
            s_next.rdata[dcc_pkg::ST_TO_BIT]     = s_reg.to_st;
        end
        else if (reg_rd_i && (reg_addr_i == dcc_pkg::CNT_OFS))
        begin
            s_next.rdata = {8'h00, s_reg.cnt};
        end
        else if (reg_rd_i && (reg_addr_i == dcc_pkg::CNT_RLD_OFS))
        begin
            s_next.rdata = {s_reg.cfg[dcc_pkg::RLDEN_BIT], 7'h00, s_reg.rld_cnt};
        end
        else if (reg_rd_i)
        begin
            s_next.rdata = '0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            s_reg           <= '0;
            s_reg.cfg       <= dcc_pkg::CFG_RESET;
            s_reg.src_bytes <= 3'h1;
            s_reg.dst_bytes <= 3'h0;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // ==================================================================
    // channel fifo
    dcc_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .sys_clk_i   (sys_clk_i),
        .rst_b_i     (rst_b_i),
        .in_valid_i  (fifo_in_valid),
        .in_data_i   (rd_data_i),
        .in_ready_o  (fifo_in_ready),
        .out_valid_o (fifo_out_valid),
        .out_data_o  (wr_data_o),
        .out_ready_i (wr_ready_i),
        .level_o     (fifo_level)
    );

    // ==================================================================
    // outputs
    assign rd_ready_o  = fifo_in_ready;
    assign wr_valid_o  = fifo_out_valid;
    assign reg_rdata_o = s_reg.rdata;
    assign reg_ack_o   = s_reg.ack;
    assign ipend_o     = s_reg.ipend;
    assign dma_req_o   = s_reg.req;
    assign pri_o       = s_reg.cfg[dcc_pkg::PRI_LSB +: 2];
    assign burst_o     = s_reg.cfg[dcc_pkg::BRST_LSB +: 5];
    assign src_inc_o   = s_reg.cfg[dcc_pkg::SRCINC_BIT];
    assign dst_inc_o   = s_reg.cfg[dcc_pkg::DSTINC_BIT];
    assign src_bytes_o = s_reg.src_bytes;
    assign dst_bytes_o = s_reg.dst_bytes;
    assign active_o    = s_reg.active;
    assign reload_o    = s_reg.reload;
    assign timeout_o   = s_reg.to_st;

endmodule : dcc_channel_config

// *** sim/dcc_props.sv ***
// port assertions for the dma channel configuration block
`timescale 1ns/10ps
module dcc_props (
    // clock and reset
    input wire logic        sys_clk_i,
    input wire logic        rst_b_i,
    // register port
    input wire logic [11:0] reg_addr_i,
    input wire logic        reg_wr_i,
    input wire logic        reg_rd_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic        reg_ack_o,
    // global enable and channel outputs
    input wire logic        glb_int_en_i,
    input wire logic        ipend_o,
    input wire logic [1:0]  pri_o,
    input wire logic [4:0]  burst_o,
    input wire logic        src_inc_o,
    input wire logic        dst_inc_o,
    input wire logic        active_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_b_i);
    // ========================================
    // configuration write events
    logic cfg_wr;
    assign cfg_wr = reg_wr_i && (reg_addr_i == dcc_pkg::CFG_OFS);
    sequence s_wr_on;
        cfg_wr && reg_wdata_i[0];
    endsequence
    // receive codes 1 to 1F
    sequence s_wr_rx;
        cfg_wr && !reg_wdata_i[9] && (reg_wdata_i[8:4] != 5'h00);
    endsequence
    a_ack_follows: assert property ((reg_wr_i || reg_rd_i) |=> reg_ack_o)
        else $error("register access not acknowledged");
    a_chen_starts: assert property (s_wr_on |=> active_o)
        else $error("enable write did not start channel");
    a_chen_stops: assert property (cfg_wr && !reg_wdata_i[0] |=> !active_o)
        else $error("disable write left channel active");
    a_pri_field: assert property (cfg_wr |=> pri_o == $past(reg_wdata_i[3:2]))
        else $error("priority not taken from write");
    a_burst_field: assert property (cfg_wr |=> burst_o == $past(reg_wdata_i[28:24]))
        else $error("burst not taken from write");
    a_srcinc_rx: assert property (s_wr_rx |=> !src_inc_o)
        else $error("source increment not forced off");
    a_dstinc_tx: assert property (cfg_wr && reg_wdata_i[9] |=> !dst_inc_o)
        else $error("destination increment not forced off");
    a_dstinc_set: assert property (cfg_wr && reg_wdata_i[22] && !reg_wdata_i[9] |=> dst_inc_o)
        else $error("destination increment not set");
    a_ipend_gated: assert property ($rose(ipend_o) |-> $past(glb_int_en_i))
        else $error("pending set without global enable");
endmodule : dcc_props

bind dcc_channel_config dcc_props dcc_props_i (
    .sys_clk_i, .rst_b_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i, .reg_ack_o,
    .glb_int_en_i, .ipend_o, .pri_o, .burst_o, .src_inc_o, .dst_inc_o, .active_o
);

// *** sim/dcc_partner.sv ***
// far side model: byte source into the fifo and a stalling byte sink
`timescale 1ns/10ps
module dcc_partner (
    // clock and reset
    input  wire logic       sys_clk_i,
    input  wire logic       rst_b_i,
    // bench control
    input  wire logic [7:0] want_i,
    input  wire logic       stall_i,
    // source side
    input  wire logic       rd_ready_o,
    output logic            rd_valid_i,
    output logic [7:0]      rd_data_i,
    // sink side
    input  wire logic       wr_valid_o,
    input  wire logic [7:0] wr_data_o,
    output logic            wr_ready_i,
    // results
    output logic [7:0]      got_o,
    output logic [7:0]      bad_o
);
    logic [7:0] sent;
    logic [7:0] nxt;
    assign nxt = sent + {7'h00, rd_valid_i && rd_ready_o};
    // idle data is inverted so a stale byte cannot pass
    assign rd_data_i = rd_valid_i ? sent : ~sent;
    // a byte stays offered until the fifo takes it
    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            sent       <= 8'h00;
            rd_valid_i <= 1'b0;
            wr_ready_i <= 1'b0;
            got_o      <= 8'h00;
            bad_o      <= 8'h00;
        end
        else
        begin
            sent       <= nxt;
            rd_valid_i <= nxt < want_i;
            wr_ready_i <= !stall_i;
            if (wr_valid_o && wr_ready_i)
            begin
                got_o <= got_o + 8'h01;
                if (wr_data_o !== got_o)
                    bad_o <= bad_o + 8'h01;
            end
        end
    end
endmodule : dcc_partner

// *** sim/tb.sv ***
// self-checking bench for the dma channel configuration block
`timescale 1ns/10ps
module tb;
    typedef struct packed {
        logic [31:0] wd;
        logic [31:0] rb;
        logic        si;
        logic        di;
    } dcc_row_t;
    // ========================================
    // signals
    logic        sys_clk_i    = 1'b0;
    logic        rst_b_i      = 1'b0;
    logic [11:0] reg_addr_i   = 12'h000;
    logic        reg_wr_i     = 1'b0;
    logic        reg_rd_i     = 1'b0;
    logic [31:0] reg_wdata_i  = 32'h0000_0000;
    logic        glb_int_en_i = 1'b0;
    logic [63:0] periph_req_i = 64'h0;
    logic [7:0]  want         = 8'h00;
    logic        stall        = 1'b1;
    logic [31:0] reg_rdata_o;
    logic [4:0]  burst_o;
    logic [2:0]  src_bytes_o, dst_bytes_o;
    logic [1:0]  pri_o;
    logic [7:0]  rd_data_i, wr_data_o, got, bad;
    logic        reg_ack_o, ipend_o, dma_req_o, src_inc_o, dst_inc_o, active_o;
    logic        reload_o, timeout_o, rd_valid_i, rd_ready_o, wr_valid_o, wr_ready_i;
    int          err_count  = 0;
    int          n_compared = 0;
    int          n_reload   = 0;
    dcc_row_t    rows [4]   = '{'{32'hFFFF_FFFE, 32'hDF37_FFFE, 1'b1, 1'b0},
                                '{32'h0045_0054, 32'h0041_0054, 1'b0, 1'b1},
                                '{32'h1F44_000C, 32'h1F44_000C, 1'b1, 1'b1},
                                '{32'h2088_0000, 32'h0000_0000, 1'b0, 1'b0}};
    always #5 sys_clk_i = ~sys_clk_i;
    // reload pulse lasts one cycle, counted away from the launching edge
    always @(negedge sys_clk_i)
        if (reload_o)
            n_reload++;
    dcc_channel_config dcc_channel_config_i (
        .sys_clk_i, .rst_b_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i,
        .reg_rdata_o, .reg_ack_o, .glb_int_en_i, .ipend_o, .periph_req_i, .dma_req_o,
        .pri_o, .burst_o, .src_inc_o, .dst_inc_o, .src_bytes_o, .dst_bytes_o,
        .active_o, .reload_o, .timeout_o, .rd_valid_i, .rd_data_i, .rd_ready_o,
        .wr_valid_o, .wr_data_o, .wr_ready_i);
    dcc_partner dcc_partner_i (
        .sys_clk_i, .rst_b_i, .want_i(want), .stall_i(stall), .rd_ready_o,
        .rd_valid_i, .rd_data_i, .wr_valid_o, .wr_data_o, .wr_ready_i,
        .got_o(got), .bad_o(bad));
    // ========================================
    // tasks
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        n_compared++;
        if (g !== e)
        begin
            err_count++;
            $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask : chk
    task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= w;
        reg_rd_i    <= !w;
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b0;
        reg_rd_i <= 1'b0;
        #1;
        chk({31'h0, reg_ack_o}, 32'h1, "ack");
    endtask : acc
    task automatic rdc(input logic [11:0] a, input logic [31:0] e, input string m);
        acc(1'b0, a, 32'h0);
        chk(reg_rdata_o, e, m);
    endtask : rdc
    task automatic xfer(input logic [7:0] n, input logic glb);
        acc(1'b1, dcc_pkg::CNT_OFS, {24'h0, n});
        acc(1'b1, dcc_pkg::CFG_OFS, 32'hC312_0001);
        @(posedge sys_clk_i);
        glb_int_en_i <= glb;
        stall        <= 1'b1;
        want         <= want + n;
        #1;
        chk({31'h0, dma_req_o}, 32'h1, "request");
        chk({26'h0, src_bytes_o, dst_bytes_o},
            {26'h0, (n < 8'd4 ? n[2:0] : 3'h4), 3'h0}, "widths");
        repeat (60) @(posedge sys_clk_i);
        #1;
        chk({31'h0, dma_req_o}, 32'h0, "request stop");
        chk({26'h0, src_bytes_o, dst_bytes_o},
            {26'h0, (n < 8'd33 ? 3'h0 : 3'h2), 3'h2}, "widths full");
        chk({31'h0, rd_ready_o}, {31'h0, n < 8'd33}, "fifo full");
        @(posedge sys_clk_i);
        stall <= 1'b0;
        for (int k = 0; k < 300 && active_o; k++)
            @(posedge sys_clk_i);
        #1;
        chk({24'h0, got}, {24'h0, want}, "drained");
        chk({24'h0, bad}, 32'h0, "byte order");
        chk({31'h0, active_o}, 32'h0, "active");
        chk({31'h0, ipend_o}, {31'h0, glb}, "pending");
        rdc(dcc_pkg::STAT_OFS, {29'h0, 1'b1, glb, 1'b0}, "status");
        rdc(dcc_pkg::CFG_OFS, 32'hC312_0000, "chen cleared");
        acc(1'b1, dcc_pkg::STAT_OFS, 32'h0000_0004);
        chk({31'h0, ipend_o}, 32'h0, "pending clear");
    endtask : xfer
    task automatic print_verdict;
        $display("compared %0d errors %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : print_verdict
    // ========================================
    // sequence
    initial
    begin
        repeat (5) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        rdc(dcc_pkg::CFG_OFS, 32'h0, "cfg reset");
        rdc(dcc_pkg::STAT_OFS, 32'h0, "status reset");
        rdc(12'h1F0, 32'h0, "unmapped");
        foreach (rows[i])
        begin
            acc(1'b1, dcc_pkg::CFG_OFS, rows[i].wd);
            rdc(dcc_pkg::CFG_OFS, rows[i].rb, "cfg readback");
            chk({30'h0, pri_o}, {30'h0, rows[i].wd[3:2]}, "pri");
            chk({27'h0, burst_o}, {27'h0, rows[i].wd[28:24]}, "burst");
            chk({31'h0, src_inc_o}, {31'h0, rows[i].si}, "srcinc");
            chk({31'h0, dst_inc_o}, {31'h0, rows[i].di}, "dstinc");
        end
        acc(1'b1, dcc_pkg::CNT_RLD_OFS, 32'h8000_0000);
        rdc(dcc_pkg::CFG_OFS, 32'h0000_0002, "reload mirror");
        xfer(8'd34, 1'b1);
        xfer(8'd2, 1'b0);
        // one byte to count-to-zero with reload armed
        acc(1'b1, dcc_pkg::CNT_OFS, 32'h0000_0001);
        acc(1'b1, dcc_pkg::CNT_RLD_OFS, 32'h8000_0002);
        acc(1'b1, dcc_pkg::CFG_OFS, 32'h0000_0003);
        want <= want + 8'd1;
        repeat (8) @(posedge sys_clk_i);
        glb_int_en_i <= 1'b1;
        rdc(dcc_pkg::CNT_OFS, 32'h0000_0002, "reloaded count");
        rdc(dcc_pkg::STAT_OFS, 32'h0000_000D, "reload status");
        chk(n_reload, 32'h1, "reload pulse");
        // prescale 256, select 0: timeout between 768 and 1024 cycles
        acc(1'b1, dcc_pkg::CFG_OFS, 32'h4000_4011);
        repeat (700) @(posedge sys_clk_i);
        #1;
        chk({31'h0, timeout_o}, 32'h0, "early timeout");
        repeat (400) @(posedge sys_clk_i);
        #1;
        chk({29'h0, timeout_o, active_o, ipend_o}, 32'h5, "timeout");
        acc(1'b1, dcc_pkg::STAT_OFS, 32'h0000_0040);
        acc(1'b1, dcc_pkg::CFG_OFS, 32'h0000_4411);
        repeat (1500) @(posedge sys_clk_i);
        #1;
        chk({30'h0, timeout_o, active_o}, 32'h1, "held timer");
        acc(1'b1, dcc_pkg::CFG_OFS, 32'h0);
        chk({31'h0, active_o}, 32'h0, "sw disable");
        print_verdict();
    end
    initial
    begin
        #300_000;
        err_count++;
        print_verdict();
    end
endmodule : tb
